// [inc/pcg_pkg.sv]
// Purpose: Constants for the peripheral clock gating block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Gate bits use 1 = module stopped.
package pcg_pkg;
    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0]  PCG_GATE_ADDR   = 8'h00;   // Gate register byte address.
    localparam logic [7:0]  PCG_STATE_ADDR  = 8'h04;   // Effective enable status byte address.
    localparam int          PCG_ADDR_WIDTH  = 8;       // APB address width used by the block.
    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int          PCG_TIMER_NINE  = 15;      // Timer nine gate bit.
    localparam int          PCG_TIMER_EIGHT = 14;      // Timer eight gate bit.
    localparam int          PCG_TIMER_SEVEN = 13;      // Timer seven gate bit.
    localparam int          PCG_TIMER_SIX   = 12;      // Timer six gate bit.
    localparam int          PCG_SECOND_I2C  = 1;       // Second I2C port gate bit.
    localparam int          PCG_SECOND_ADC  = 0;       // Second ADC gate bit.
    localparam logic [15:0] PCG_IMPL_MASK   = 16'hF003; // Bits that exist in the gate register.
    localparam logic [15:0] PCG_GATE_RESET  = 16'h0000; // Every present module starts enabled.
    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int          PCG_INSTR_CYCLES = 1;      // Delay from write to effect, instruction cycles.
    localparam int          PCG_CLK_PER_INSTR = 1;     // Core clocks per instruction cycle.
    localparam int          PCG_DELAY_CLKS  = PCG_INSTR_CYCLES * PCG_CLK_PER_INSTR;
endpackage : pcg_pkg

// [verilog/pcg_clock_gate.sv]
// Purpose: Glitch-free clock gate for one peripheral.
// Assumes: Enable changes only after a rising edge of the clock.
// Notes:   Latch-free form: enable retimed on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module pcg_clock_gate (
    input  wire logic clk_in,   // Clock to be gated.
    input  wire logic enable,   // High lets the clock pass.
    output logic      clk_out   // Gated clock.
);
    // -----------------------------------------------------------------
    // Gate
    // -----------------------------------------------------------------
    logic enable_low;           // Enable held stable while the clock is high.

    // Retime on the falling edge so the AND never chops a high phase.
    always_ff @(negedge clk_in) begin
        enable_low <= enable;
    end

    // Pass the clock only while the retimed enable is high.
    assign clk_out = clk_in & enable_low;
endmodule : pcg_clock_gate
`default_nettype wire

// [verilog/pcg_top.sv]
// Purpose: Per-peripheral clock gating with an APB gate register.
// Assumes: SRST synchronous active high; CORE_CLK at 125 MHz.
// Notes:   Gate bits use 1 = module stopped; the rules follow.
// Notes on behaviour
// R01: Set gate bit stops that module's clocks.
// R02: Disabled module's register writes blocked, reads undefined.
// R03: Enabled only if gate clear and implemented.
// R04: Implemented gate bits reset to clear.
// R05: Setting a bit disables after one cycle.
// R06: Clearing re-enables after one cycle, if configured.
// R07: ADC gated makes analog config ineffective.
// R08: ADC gated makes shared pins digital.
// R09: Bits 15-12 timers, 1 I2C, 0 ADC.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module pcg_top #(
    parameter logic [5:0] PRESENT    = 6'h3F,  // Which modules exist: {t9,t8,t7,t6,i2c,adc}.
    parameter int         ANALOG_PINS = 16     // Pins shared with the second ADC.
) (
    input  wire logic                              CORE_CLK,
    input  wire logic                              SRST,
    input  wire logic                              PSEL,
    input  wire logic                              PENABLE,
    input  wire logic                              PWRITE,
    input  wire logic [pcg_pkg::PCG_ADDR_WIDTH-1:0] PADDR,
    input  wire logic [31:0]                       PWDATA,
    input  wire logic [3:0]                        PSTRB,
    output logic      [31:0]                       PRDATA,
    output logic                                   PREADY,
    output logic                                   PSLVERR,
    input  wire logic [5:0]                        MODULE_CFG_ON,
    input  wire logic [ANALOG_PINS-1:0]            ANALOG_PIN_CONFIG,
    output logic      [5:0]                        MODULE_RUN,
    output logic      [5:0]                        MODULE_REG_ACCESS,
    output logic      [ANALOG_PINS-1:0]            ANALOG_PIN_MODE,
    output logic      [5:0]                        MODULE_CLK
);
    import pcg_pkg::*;

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    logic [15:0] module_clock_gate;        // Software gate register.
    logic [15:0] next_module_clock_gate;   // Next value of the gate register.
    logic [5:0]  enabled;                  // Registered effective enables.
    logic [5:0]  next_enabled;             // Next effective enables.
    logic [5:0]  run;                      // Enable and module configuration.
    logic [5:0]  next_run;                 // Next run value.
    logic [ANALOG_PINS-1:0] pin_mode;      // Registered analog pin mode.
    logic [ANALOG_PINS-1:0] next_pin_mode; // Next analog pin mode.
    logic [31:0] rdata;                    // Registered read data.
    logic [31:0] next_rdata;               // Next read data.
    logic        ready;                    // Registered ready.
    logic        next_ready;               // Next ready.
    logic        slverr;                   // Registered error.
    logic        next_slverr;              // Next error.
    logic        access;                   // APB access phase, first cycle.

    // Gather the six gate bits into one compact vector.
    function automatic logic [5:0] pack_gates(input logic [15:0] g);
        pack_gates = {g[PCG_TIMER_NINE], g[PCG_TIMER_EIGHT], g[PCG_TIMER_SEVEN],
                      g[PCG_TIMER_SIX], g[PCG_SECOND_I2C], g[PCG_SECOND_ADC]};
    endfunction : pack_gates

    // -----------------------------------------------------------------
    // APB slave
    // -----------------------------------------------------------------
    // Answer in the second access-phase cycle; ready drops after the handshake.
    assign access = PSEL & PENABLE & ~ready;

    // Decode writes and reads of the two registers.
    always_comb begin
        next_module_clock_gate = module_clock_gate;
        next_rdata             = rdata;
        next_ready             = access;
        next_slverr            = 1'b0;
        if (access) begin
            if (PADDR == PCG_GATE_ADDR) begin
                // Only implemented bits are writable, also those of modules that are not present.
                if (PWRITE) begin
                    if (PSTRB[0]) begin
                        next_module_clock_gate[7:0] = PWDATA[7:0] & PCG_IMPL_MASK[7:0]; // R09
                    end
                    if (PSTRB[1]) begin
                        next_module_clock_gate[15:8] = PWDATA[15:8] & PCG_IMPL_MASK[15:8]; // R09
                    end
                end else begin
                    next_rdata = {16'h0000, module_clock_gate}; // R09
                end
            end else if (PADDR == PCG_STATE_ADDR) begin
                // Status shows which modules are live now.
                if (PWRITE) begin
                    next_slverr = 1'b1;
                end else begin
                    next_rdata = {26'h0000000, enabled};
                end
            end else begin
                // Unmapped address: error, read returns zero.
                next_slverr = 1'b1;
                next_rdata  = 32'h00000000;
            end
        end
        if (SRST) begin
            next_module_clock_gate = PCG_GATE_RESET; // R04
            next_rdata             = 32'h00000000;
            next_ready             = 1'b0;
            next_slverr            = 1'b0;
        end
    end

    // Register the bus state.
    always_ff @(posedge CORE_CLK) begin
        module_clock_gate <= next_module_clock_gate;
        rdata             <= next_rdata;
        ready             <= next_ready;
        slverr            <= next_slverr;
    end

    // -----------------------------------------------------------------
    // Gating
    // -----------------------------------------------------------------
    // Effective enables lag the gate register by one cycle.
    always_comb begin
        next_enabled  = ~pack_gates(module_clock_gate) & PRESENT; // R03 R05 R06
        next_run      = enabled & MODULE_CFG_ON;                   // R06
        // A gated ADC forces every shared pin digital, ignoring config.
        next_pin_mode = enabled[0] ? ANALOG_PIN_CONFIG : '0;       // R07 R08
        if (SRST) begin
            next_enabled  = PRESENT;                                // R04
            next_run      = 6'h00;
            next_pin_mode = '0;
        end
    end

    // Register the effective enables.
    always_ff @(posedge CORE_CLK) begin
        enabled  <= next_enabled;
        run      <= next_run;
        pin_mode <= next_pin_mode;
    end

    // One gate per module stops its clock while it is disabled.
    for (genvar i = 0; i < 6; i++) begin : g_gate
        pcg_clock_gate u_gate (
            .clk_in  (CORE_CLK),
            .enable  (enabled[i]),  // R01
            .clk_out (MODULE_CLK[i])
        );
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign PRDATA            = rdata;
    assign PREADY            = ready;
    assign PSLVERR           = slverr;
    assign MODULE_RUN        = run;
    assign MODULE_REG_ACCESS = enabled;  // R02
    assign ANALOG_PIN_MODE   = pin_mode;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    property p_delay;
        @(posedge CORE_CLK) disable iff (SRST)
        1'b1 |=> enabled == ($past(~pack_gates(module_clock_gate)) & PRESENT);
    endproperty
    a_delay: assert property (p_delay) else $error("enable lag wrong"); // R05

    // A set gate bit closes the register access of the second I2C port.
    property p_access;
        @(posedge CORE_CLK) disable iff (SRST)
        module_clock_gate[PCG_SECOND_I2C] |=> !MODULE_REG_ACCESS[1];
    endproperty
    a_access: assert property (p_access) else $error("access gate wrong"); // R02

    property p_absent;
        @(posedge CORE_CLK) disable iff (SRST)
        (enabled & ~PRESENT) == 6'h00;
    endproperty
    a_absent: assert property (p_absent) else $error("absent module enabled"); // R03

    property p_reset;
        @(posedge CORE_CLK) $past(SRST) |-> module_clock_gate == PCG_GATE_RESET;
    endproperty
    a_reset: assert property (p_reset) else $error("gate not cleared"); // R04

    property p_run;
        @(posedge CORE_CLK) disable iff (SRST)
        !SRST |=> run == $past(enabled & MODULE_CFG_ON);
    endproperty
    a_run: assert property (p_run) else $error("run wrong"); // R06

    property p_pins;
        @(posedge CORE_CLK) disable iff (SRST)
        $past(~enabled[0]) |-> ANALOG_PIN_MODE == '0;
    endproperty
    a_pins: assert property (p_pins) else $error("pins not digital"); // R07

    // The ADC gate bit needs one cycle to reach the enable and one more for the pins.
    sequence s_adc_gated;
        module_clock_gate[PCG_SECOND_ADC] ##2 1'b1;
    endsequence

    property p_digital;
        @(posedge CORE_CLK) disable iff (SRST)
        s_adc_gated |-> ANALOG_PIN_MODE == '0;
    endproperty
    a_digital: assert property (p_digital) else $error("shared pins analog"); // R08

    property p_reserved;
        @(posedge CORE_CLK) disable iff (SRST)
        (module_clock_gate & ~PCG_IMPL_MASK) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set"); // R09

    property p_stop;
        @(posedge CORE_CLK) disable iff (SRST)
        module_clock_gate[PCG_TIMER_SIX] |=> !enabled[2];
    endproperty
    a_stop: assert property (p_stop) else $error("timer six not stopped"); // R01
endmodule : pcg_top
`default_nettype wire

// [sim/pcg_top_tb.sv]
// Purpose: Self-checking bench for the peripheral clock gating block.
// Assumes: APB answer comes from the design; the bench waits for PREADY.
// Notes:   All compares go through chk; results gives the verdict.
`timescale 1ns/1ns
`default_nettype none
module pcg_top_tb;
    import pcg_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        core_clk = 1'b0;       // Core clock, 8 ns period.
    logic        srst     = 1'b1;       // Synchronous reset, high.
    logic        psel     = 1'b0;       // APB select.
    logic        penable  = 1'b0;       // APB access phase.
    logic        pwrite   = 1'b0;       // APB direction.
    logic [7:0]  paddr    = 8'h00;      // APB byte address.
    logic [31:0] pwdata   = 32'h0;      // APB write data.
    logic [3:0]  pstrb    = 4'hF;       // APB byte strobes.
    logic [5:0]  cfg_on   = 6'h3F;      // Modules' own enables.
    logic [15:0] pin_cfg  = 16'hA5C3;   // Analog request per pin.
    logic [31:0] prdata;                // Read data.
    logic        pready;                // Transfer done.
    logic        pslverr;               // Transfer refused.
    logic [5:0]  run;                   // Modules running.
    logic [5:0]  acc;                   // Register access open.
    logic [15:0] pin_mode;              // Pins in analog mode.
    logic [5:0]  mclk;                  // Gated clocks.
    logic [31:0] rd;                    // Read data taken at completion.
    logic        err;                   // Error taken at completion.
    int          fail_count = 0;        // Mismatches seen.
    int          cmp_count  = 0;        // Compares made.
    int          cyc        = 0;        // Watchdog cycle count.
    pcg_top u_dut (.CORE_CLK(core_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .MODULE_CFG_ON(cfg_on), .ANALOG_PIN_CONFIG(pin_cfg),
        .MODULE_RUN(run), .MODULE_REG_ACCESS(acc), .ANALOG_PIN_MODE(pin_mode), .MODULE_CLK(mclk));
    // Free-running clock.
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    // Watchdog: a hang counts as a mismatch and ends the run.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            results();
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Compare one value with its expectation.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; request held until PREADY is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    // Print the counts and the verdict, then stop.
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset state: gate clear, every present module enabled.
    task automatic test_reset();
        chk(32'(acc), 32'h3F);
        apb(1'b0, PCG_GATE_ADDR, 32'h0, 4'hF);
        chk(rd, 32'h0);
        apb(1'b0, PCG_STATE_ADDR, 32'h0, 4'hF);
        chk(rd, 32'h3F);
        $display("test_reset done");
    endtask : test_reset
    // All bits set: only six stick, ADC pins go digital.
    task automatic test_fields();
        apb(1'b1, PCG_GATE_ADDR, 32'hFFFF, 4'hF);
        apb(1'b0, PCG_GATE_ADDR, 32'h0, 4'hF);
        chk(rd, 32'hF003);
        apb(1'b0, PCG_STATE_ADDR, 32'h0, 4'hF);
        chk(rd, 32'h0);
        chk(32'(pin_mode), 32'h0);
        apb(1'b1, PCG_GATE_ADDR, 32'h0, 4'hF);
        repeat (2) @(posedge core_clk);
        #1 chk(32'(pin_mode), 32'hA5C3);
        $display("test_fields done");
    endtask : test_fields
    // Each gate bit: one-cycle delay both ways, clock stops.
    task automatic test_timing();
        logic [5:0] b;
        for (int i = 0; i < 6; i++) begin
            b = ~(6'h1 << i);
            apb(1'b1, PCG_GATE_ADDR, 32'h1 << (i < 2 ? i : i + 10), 4'h3);
            chk(32'(acc), 32'(b));
            chk(32'(run), 32'h3F);
            @(posedge core_clk);
            #1 chk(32'(run), 32'(b));
            #2 chk(32'(mclk), 32'(b));
            apb(1'b1, PCG_GATE_ADDR, 32'h0, 4'h3);
            chk(32'(acc), 32'h3F);
            @(posedge core_clk);
            #1 chk(32'(run), 32'h3F);
        end
        @(posedge core_clk);
        cfg_on <= 6'h3E;
        repeat (2) @(posedge core_clk);
        #1 chk(32'(run), 32'h3E);
        @(posedge core_clk);
        cfg_on <= 6'h3F;
        $display("test_timing done");
    endtask : test_timing
    // Refused writes and byte strobes.
    task automatic test_refuse();
        apb(1'b1, PCG_STATE_ADDR, 32'hFFFF, 4'hF);
        chk(32'(err), 32'h1);
        apb(1'b1, 8'h08, 32'hFFFF, 4'hF);
        chk(32'(err), 32'h1);
        apb(1'b0, 8'h08, 32'h0, 4'hF);
        chk(rd, 32'h0);
        apb(1'b1, PCG_GATE_ADDR, 32'hFFFF, 4'h1);
        apb(1'b0, PCG_GATE_ADDR, 32'h0, 4'hF);
        chk(rd, 32'h0003);
        apb(1'b1, PCG_GATE_ADDR, 32'hFFFF, 4'h2);
        apb(1'b0, PCG_GATE_ADDR, 32'h0, 4'hF);
        chk(rd, 32'hF003);
        apb(1'b1, PCG_GATE_ADDR, 32'h0, 4'hF);
        $display("test_refuse done");
    endtask : test_refuse
    // Main sequence: reset held four cycles, then the scenarios.
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        #1 test_reset();
        test_fields();
        test_timing();
        test_refuse();
        results();
    end
endmodule : pcg_top_tb
`default_nettype wire
